// ==== design/hbps_channel.sv ====
// one pwm channel: working duty, alignment and pin steering
`timescale 1ns/1ps
`default_nettype none
module hbps_channel
   import hbps_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [hbps_pkg::DUTY_W-1:0] i_cnt,
   input wire logic [hbps_pkg::DUTY_W-1:0] i_period,
   input wire logic i_ovf,
   input wire logic [1:0] i_align,
   input wire logic [1:0] i_mode,
   input wire logic i_freewheel,
   input wire logic [hbps_pkg::DUTY_W-1:0] i_duty,
   input wire logic i_sign,
   output logic o_plus_pin,
   output logic o_plus_oe_n,
   output logic o_minus_pin,
   output logic o_minus_oe_n
);
   // ==========================================================
   // working copies and period parity
   logic [DUTY_W-1:0] work_duty_r;
   logic work_sign_r;
   logic odd_r;
   wire enabled = (i_align != ALIGN_OFF);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         work_duty_r <= RST_DUTY;
         work_sign_r <= 1'b0;
      end else if (i_ovf) begin
         work_duty_r <= i_duty;
         work_sign_r <= i_sign;
      end
   end

   // parity only restarts at reset or when the channel is off, so a live switch
   // into center mode keeps whatever phase it had
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !enabled) begin
         odd_r <= 1'b0;
      end else if (i_ovf) begin
         odd_r <= ~odd_r;
      end
   end

   // ==========================================================
   // active phase
   wire [DUTY_W:0] cnt_x = {1'b0, i_cnt};
   wire [DUTY_W:0] duty_x = {1'b0, work_duty_r};
   wire [DUTY_W:0] per_x = {1'b0, i_period};
   wire left_act = cnt_x < duty_x;
   wire right_act = (cnt_x + duty_x) >= per_x;
   wire use_right = (i_align == ALIGN_RIGHT) || ((i_align == ALIGN_CENTER) && odd_r);
   wire active = use_right ? right_act : left_act;

   // ==========================================================
   // pin steering
   wire full_mode = i_mode[1];
   wire pwm_low_act = ~active;
   wire full_pwm = i_freewheel ? active : pwm_low_act;
   wire full_static = ~i_freewheel;
   wire pwm_on_plus = work_sign_r ^ i_freewheel;
   logic plus_nxt;
   logic minus_nxt;
   logic plus_oe_n_nxt;
   logic minus_oe_n_nxt;

   always_comb begin
      plus_nxt = 1'b0;
      minus_nxt = 1'b0;
      plus_oe_n_nxt = 1'b1;
      minus_oe_n_nxt = 1'b1;
      if (!enabled) begin
         plus_oe_n_nxt = 1'b1;
         minus_oe_n_nxt = 1'b1;
      end else if (full_mode) begin
         plus_oe_n_nxt = 1'b0;
         minus_oe_n_nxt = 1'b0;
         plus_nxt = pwm_on_plus ? full_pwm : full_static;
         minus_nxt = pwm_on_plus ? full_static : full_pwm;
      end else if (i_mode == MODE_HALF_PLUS) begin
         // sign and freewheel never reach the half paths
         plus_oe_n_nxt = 1'b0;
         plus_nxt = pwm_low_act;
      end else begin
         minus_oe_n_nxt = 1'b0;
         minus_nxt = pwm_low_act;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_plus_pin <= 1'b0;
         o_minus_pin <= 1'b0;
         o_plus_oe_n <= 1'b1;
         o_minus_oe_n <= 1'b1;
      end else begin
         o_plus_pin <= plus_nxt;
         o_minus_pin <= minus_nxt;
         o_plus_oe_n <= plus_oe_n_nxt;
         o_minus_oe_n <= minus_oe_n_nxt;
      end
   end
endmodule : hbps_channel
`default_nettype wire

// ==== design/hbps_top.sv ====
// h-bridge pwm output steering: registers, timer counter, eight channels
//
// Summary of operation
// - every mode reloads working duty at overflow
// - half modes: one pin pwm, other released
// - sign ignored in half modes
// - dual only if both enabled and both 11
// - left: start active, inactive after duty
// - right: active after period minus duty
// - center: even left, odd right, start even
// - live switch to center may start odd
// - freewheel 0, sign 0: plus high, minus pwm
// - freewheel 0, sign 1: minus high, plus pwm
// - freewheel 1 inverts sign, pwm high active
// - non-pwm pin high or low per freewheel
// - freewheel only matters in full modes
// - disabled channel controls no transistor
// - half 00 uses minus pin, 01 plus
// - full modes transistor pattern per sign, freewheel
// - reset disables channels, releases pins
// - pair n holds channels 2n and 2n+1
// - dual pair duties load together at overflow
`timescale 1ns/1ps
`default_nettype none
module hbps_top
   import hbps_pkg::*;
#(
   parameter int unsigned P_NUM_CH = hbps_pkg::NUM_CH
)(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [hbps_pkg::ADDR_W-1:0] i_addr,
   input wire logic [hbps_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [hbps_pkg::DATA_W-1:0] o_rdata,
   output logic [P_NUM_CH-1:0] o_plus_pin,
   output logic [P_NUM_CH-1:0] o_plus_oe_n,
   output logic [P_NUM_CH-1:0] o_minus_pin,
   output logic [P_NUM_CH-1:0] o_minus_oe_n
);
   import hbps_pkg::*;

   localparam int unsigned NP = P_NUM_CH / 2;
   localparam int unsigned EN_W = ST_CNT_LSB - ST_EN_LSB;
   localparam int unsigned DUAL_W = ST_EN_LSB - ST_DUAL_LSB;

   // ==========================================================
   // address decode
   wire [2:0] bank = i_addr[ADDR_W-1:BANK_LSB];
   wire [2:0] idx = i_addr[BANK_LSB-1:IDX_LSB];
   wire hit_global = (i_addr == ADDR_GLOBAL);
   wire hit_period = (i_addr == ADDR_PERIOD);
   wire hit_status = (i_addr == ADDR_STATUS);
   wire hit_chctrl = (bank == ADDR_CHCTRL_BASE[ADDR_W-1:BANK_LSB]) && (i_addr[1:0] == 2'h0);
   wire hit_duty = (bank == ADDR_DUTY_BASE[ADDR_W-1:BANK_LSB]) && (i_addr[1:0] == 2'h0);
   wire wr_global = i_wr && hit_global;
   wire wr_period = i_wr && hit_period;

   // ==========================================================
   // software registers
   logic freewheel_side_sel_r;
   logic [DUTY_W-1:0] period_r;
   logic [1:0] align_mode_sel_r [P_NUM_CH];
   logic [1:0] output_mode_sel_r [P_NUM_CH];
   logic [DUTY_W-1:0] duty_r [P_NUM_CH];
   logic sign_r [P_NUM_CH];

   // software keeps this steady while any channel is in a full mode
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         freewheel_side_sel_r <= RST_FREEWHEEL;
      end else if (wr_global) begin
         freewheel_side_sel_r <= i_wdata[GC_FREEWHEEL_BIT];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         period_r <= RST_PERIOD;
      end else if (wr_period) begin
         period_r <= i_wdata[DUTY_W-1:0];
      end
   end

   // ==========================================================
   // timer counter, 0 .. period-1; a zero period holds it at zero
   logic [DUTY_W-1:0] cnt_r;
   wire [DUTY_W-1:0] last_cnt = period_r - 11'h001;
   wire ovf = (period_r != RST_PERIOD) && (cnt_r >= last_cnt);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || ovf || (period_r == RST_PERIOD)) begin
         cnt_r <= 11'h000;
      end else begin
         cnt_r <= cnt_r + 11'h001;
      end
   end

   // ==========================================================
   // per-channel registers and channel instances
   logic [P_NUM_CH-1:0] ch_en;
   logic [NP-1:0] pair_dual;

   genvar g;
   generate
      for (g = 0; g < P_NUM_CH; g++) begin : g_ch
         wire wr_cc = i_wr && hit_chctrl && (idx == 3'(g));
         wire wr_dc = i_wr && hit_duty && (idx == 3'(g));

         always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
               align_mode_sel_r[g] <= RST_ALIGN;
               output_mode_sel_r[g] <= RST_MODE;
            end else if (wr_cc) begin
               align_mode_sel_r[g] <= i_wdata[CC_ALIGN_LSB+:2];
               output_mode_sel_r[g] <= i_wdata[CC_MODE_LSB+:2];
            end
         end

         // a later write before overflow simply overwrites the staged value
         always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
               duty_r[g] <= RST_DUTY;
               sign_r[g] <= 1'b0;
            end else if (wr_dc) begin
               duty_r[g] <= i_wdata[DUTY_W-1:0];
               sign_r[g] <= i_wdata[DUTY_SIGN_BIT];
            end
         end

         assign ch_en[g] = (align_mode_sel_r[g] != ALIGN_OFF);

         // both channels of a pair see the same overflow pulse, so the
         // two working duties always change on one edge
         hbps_channel u_ch (
            .i_clk_sys(i_clk_sys),
            .i_rst(i_rst),
            .i_cnt(cnt_r),
            .i_period(period_r),
            .i_ovf(ovf),
            .i_align(align_mode_sel_r[g]),
            .i_mode(output_mode_sel_r[g]),
            .i_freewheel(freewheel_side_sel_r),
            .i_duty(duty_r[g]),
            .i_sign(sign_r[g]),
            .o_plus_pin(o_plus_pin[g]),
            .o_plus_oe_n(o_plus_oe_n[g]),
            .o_minus_pin(o_minus_pin[g]),
            .o_minus_oe_n(o_minus_oe_n[g])
         );
      end

      for (g = 0; g < NP; g++) begin : g_pair
         // channels 2n and 2n+1 form pair n
         assign pair_dual[g] = ch_en[2*g] && ch_en[2*g+1]
            && (output_mode_sel_r[2*g] == MODE_DUAL)
            && (output_mode_sel_r[2*g+1] == MODE_DUAL);
      end
   endgenerate

   // ==========================================================
   // read path, data valid the cycle after the strobe
   wire [2:0] sel = idx;
   wire [DATA_W-1:0] rd_global = {{(DATA_W-1){1'b0}}, freewheel_side_sel_r};
   wire [DATA_W-1:0] rd_period = {{(DATA_W-DUTY_W){1'b0}}, period_r};
   wire [DATA_W-1:0] rd_cc = {{(DATA_W-CC_MODE_LSB-2){1'b0}}, output_mode_sel_r[sel],
                              2'h0, align_mode_sel_r[sel]};
   wire [DATA_W-1:0] rd_dc = {{(DATA_W-DUTY_SIGN_BIT-1){1'b0}}, sign_r[sel],
                              {(DUTY_SIGN_BIT-DUTY_W){1'b0}}, duty_r[sel]};
   // fields padded by cast, so a full channel count needs no empty replication
   wire [EN_W-1:0] en_field = EN_W'(ch_en);
   wire [DUAL_W-1:0] dual_field = DUAL_W'(pair_dual);
   wire [DATA_W-1:0] rd_status = {{(DATA_W-ST_CNT_LSB-DUTY_W){1'b0}}, cnt_r,
                                  en_field, dual_field};
   logic [DATA_W-1:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_global) begin
         rd_mux = rd_global;
      end else if (hit_period) begin
         rd_mux = rd_period;
      end else if (hit_status) begin
         rd_mux = rd_status;
      end else if (hit_chctrl) begin
         rd_mux = rd_cc;
      end else if (hit_duty) begin
         rd_mux = rd_dc;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         o_rdata <= rd_mux;
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end
endmodule : hbps_top
`default_nettype wire

// ==== include/hbps_pkg.sv ====
// constants for the h-bridge pwm output steering block
`default_nettype none
package hbps_pkg;
   // ==========================================================
   // sizes
   localparam int unsigned NUM_CH = 8;
   localparam int unsigned NUM_PAIR = 4;
   localparam int unsigned DUTY_W = 11;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // ==========================================================
   // register map, one 32-bit word each
   localparam logic [7:0] ADDR_GLOBAL = 8'h00;
   localparam logic [7:0] ADDR_PERIOD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CHCTRL_BASE = 8'h20;
   localparam logic [7:0] ADDR_DUTY_BASE = 8'h40;
   localparam int unsigned BANK_LSB = 5;
   localparam int unsigned IDX_LSB = 2;

   // ==========================================================
   // field positions
   localparam int unsigned GC_FREEWHEEL_BIT = 0;
   localparam int unsigned CC_ALIGN_LSB = 0;
   localparam int unsigned CC_MODE_LSB = 4;
   localparam int unsigned DUTY_SIGN_BIT = 15;
   localparam int unsigned ST_DUAL_LSB = 0;
   localparam int unsigned ST_EN_LSB = 8;
   localparam int unsigned ST_CNT_LSB = 16;

   // ==========================================================
   // reset values
   localparam logic [1:0] RST_ALIGN = 2'h0;
   localparam logic [1:0] RST_MODE = 2'h0;
   localparam logic [DUTY_W-1:0] RST_DUTY = 11'h000;
   localparam logic [DUTY_W-1:0] RST_PERIOD = 11'h000;
   localparam logic RST_FREEWHEEL = 1'b0;

   // ==========================================================
   // field codes
   localparam logic [1:0] ALIGN_OFF = 2'h0;
   localparam logic [1:0] ALIGN_LEFT = 2'h1;
   localparam logic [1:0] ALIGN_RIGHT = 2'h2;
   localparam logic [1:0] ALIGN_CENTER = 2'h3;
   localparam logic [1:0] MODE_HALF_MINUS = 2'h0;
   localparam logic [1:0] MODE_HALF_PLUS = 2'h1;
   localparam logic [1:0] MODE_FULL = 2'h2;
   localparam logic [1:0] MODE_DUAL = 2'h3;
endpackage : hbps_pkg
`default_nettype wire

// ==== tb/hbps_assertions.sv ====
// port-level assertions for the steering block
`timescale 1ns/1ps
`default_nettype none
module hbps_assertions
   import hbps_pkg::*;
#(
   parameter int unsigned P_NUM_CH = 8
)(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [hbps_pkg::ADDR_W-1:0] i_addr,
   input wire logic [hbps_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [hbps_pkg::DATA_W-1:0] o_rdata,
   input wire logic [P_NUM_CH-1:0] o_plus_pin,
   input wire logic [P_NUM_CH-1:0] o_plus_oe_n,
   input wire logic [P_NUM_CH-1:0] o_minus_pin,
   input wire logic [P_NUM_CH-1:0] o_minus_oe_n
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // ==========================================================
   // helpers: freewheel shadow, pins driven on both sides
   logic fw_r;
   wire logic fw_nxt = (i_wr && i_addr == ADDR_GLOBAL) ? i_wdata[0] : fw_r;
   always_ff @(posedge i_clk_sys) fw_r <= i_rst ? 1'b0 : fw_nxt;
   wire logic [P_NUM_CH-1:0] both_drv = ~o_plus_oe_n & ~o_minus_oe_n;
   wire logic ch0_wr = i_wr && i_addr == ADDR_CHCTRL_BASE;
   wire logic ch0_on = ch0_wr && i_wdata[1:0] != ALIGN_OFF;
   sequence s_per_wr;
      i_wr && i_addr == ADDR_PERIOD;
   endsequence
   sequence s_per_rd;
      i_rd && i_addr == ADDR_PERIOD;
   endsequence
   // ==========================================================
   // assertions
   a_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == '0)
      else $error("misaligned read not zero");
   a_period_back: assert property (s_per_wr ##2 s_per_rd
      |=> o_rdata == {{(DATA_W-DUTY_W){1'b0}}, $past(i_wdata[DUTY_W-1:0], 3)})
      else $error("period read back differs");
   a_reset_release:
      assert property (disable iff (1'b0) i_rst |=> (&o_plus_oe_n) && (&o_minus_oe_n))
      else $error("pins not released after reset");
   a_fw0_static:
      assert property (!fw_r |-> (both_drv & ~o_plus_pin & ~o_minus_pin) == '0)
      else $error("no static high pin with freewheel 0");
   a_fw1_static:
      assert property (fw_r |-> (both_drv & o_plus_pin & o_minus_pin) == '0)
      else $error("no static low pin with freewheel 1");
   a_off_release:
      assert property (ch0_wr && i_wdata[1:0] == ALIGN_OFF |-> ##2 o_plus_oe_n[0] && o_minus_oe_n[0])
      else $error("disabled channel still drives");
   a_half_minus:
      assert property (ch0_on && i_wdata[5:4] == MODE_HALF_MINUS
         |-> ##2 !o_minus_oe_n[0] && o_plus_oe_n[0]) else $error("half minus pin wrong");
   a_half_plus:
      assert property (ch0_on && i_wdata[5:4] == MODE_HALF_PLUS
         |-> ##2 !o_plus_oe_n[0] && o_minus_oe_n[0]) else $error("half plus pin wrong");
   a_full_both:
      assert property (ch0_on && i_wdata[5] |-> ##2 both_drv[0])
      else $error("full mode not driving both pins");
endmodule : hbps_assertions
bind hbps_top hbps_assertions #(.P_NUM_CH(P_NUM_CH)) u_chk (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_plus_pin(o_plus_pin),
   .o_plus_oe_n(o_plus_oe_n), .o_minus_pin(o_minus_pin), .o_minus_oe_n(o_minus_oe_n));
`default_nettype wire

// ==== tb/hbps_bridge_model.sv ====
// transistor-level model of the external h-bridge on the pin side
`timescale 1ns/1ps
`default_nettype none
module hbps_bridge_model (
   input wire logic [7:0] i_plus_pin,
   input wire logic [7:0] i_plus_oe_n,
   input wire logic [7:0] i_minus_pin,
   input wire logic [7:0] i_minus_oe_n,
   output logic [7:0] o_first_tr,
   output logic [7:0] o_second_tr,
   output logic [7:0] o_third_tr,
   output logic [7:0] o_fourth_tr
);
   // ==========================================================
   // a released pin leaves both of its transistors to other drivers
   assign o_first_tr = ~i_plus_oe_n & i_plus_pin;
   assign o_second_tr = ~i_plus_oe_n & ~i_plus_pin;
   assign o_third_tr = ~i_minus_oe_n & i_minus_pin;
   assign o_fourth_tr = ~i_minus_oe_n & ~i_minus_pin;
endmodule : hbps_bridge_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking testbench for the steering block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
   import hbps_pkg::*;
   localparam logic [10:0] PER = 11'h004;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic fw_s = 1'b0;
   logic [31:0] rdata;
   logic [7:0] pp, poe, mp, moe, first_tr, second_tr, third_tr, fourth_tr;
   int n_fail = 0;
   int n_tests = 0;
   hbps_top u_dut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_plus_pin(pp), .o_plus_oe_n(poe),
      .o_minus_pin(mp), .o_minus_oe_n(moe));
   hbps_bridge_model u_br (.i_plus_pin(pp), .i_plus_oe_n(poe), .i_minus_pin(mp),
      .i_minus_oe_n(moe), .o_first_tr(first_tr), .o_second_tr(second_tr),
      .o_third_tr(third_tr), .o_fourth_tr(fourth_tr));
   initial begin
      forever #2 clk = ~clk;
   end
   // ==========================================================
   // bus tasks
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   // wait lets the staged duty reach the working copy at an overflow
   task automatic cfg(input int ch, input logic [1:0] al, input logic [1:0] md,
                      input logic sg, input logic [10:0] d);
      wr_reg(ADDR_DUTY_BASE + 8'(4 * ch), {16'h0000, sg, 4'h0, d});
      wr_reg(ADDR_CHCTRL_BASE + 8'(4 * ch), {26'h000_0000, md, 2'h0, al});
      repeat (12) @(posedge clk);
   endtask : cfg
   task automatic set_fw(input logic f);
      cfg(0, ALIGN_OFF, MODE_HALF_MINUS, 1'b0, 11'h000);
      wr_reg(ADDR_GLOBAL, {31'h0000_0000, f});
      fw_s = f;
   endtask : set_fw
   // reads the counter every cycle and compares the transistor set
   task automatic watch(input int ch, input logic [1:0] al, input logic [1:0] md,
                        input logic sg, input logic [10:0] d);
      logic [10:0] c;
      logic [3:0] got, e_act, e_pas;
      int h0, h3;
      h0 = 0;
      h3 = 0;
      e_act = md[1] ? (sg ? 4'h6 : 4'h9) : (md[0] ? 4'h4 : 4'h1);
      e_pas = md[1] ? (fw_s ? 4'h5 : 4'ha) : (md[0] ? 4'h8 : 4'h2);
      if (al == ALIGN_OFF) begin
         e_act = 4'h0;
         e_pas = 4'h0;
      end
      @(posedge clk);
      addr <= ADDR_STATUS;
      rd <= 1'b1;
      for (int k = 1; k <= 16; k++) begin
         @(posedge clk);
         if (k == 16) rd <= 1'b0;
         #1 c = rdata[26:16];
         got = {first_tr[ch], second_tr[ch], third_tr[ch], fourth_tr[ch]};
         if (al == ALIGN_CENTER) begin
            h0 += int'(c == 0 && got === e_act);
            h3 += int'(c == 3 && got === e_act);
            // counts where both halves agree need no parity knowledge
            if ((c < d) == (c + d >= PER)) `CHK("center_fixed", (c < d) ? e_act : e_pas, got)
         end else begin
            `CHK("bridge", ((al == ALIGN_LEFT) ? (c < d) : (c + d >= PER)) ? e_act : e_pas, got)
         end
      end
      if (al == ALIGN_CENTER) `CHK("center", 1'b1, h0 > 0 && h3 > 0)
   endtask : watch
   // staged values read back as written, not the working copies
   task automatic regs_back;
      logic [31:0] v;
      rd_reg(ADDR_DUTY_BASE + 8'h0c, v);
      `CHK("duty_back", 32'h0000_8001, v)
      rd_reg(ADDR_CHCTRL_BASE + 8'h0c, v);
      `CHK("ctrl_back", 32'h0000_0032, v)
      rd_reg(ADDR_GLOBAL, v);
      `CHK("fw_back", 32'h0000_0000, v)
   endtask : regs_back
   // reset in mid-run with channels live must release every pin
   task automatic reset_mid;
      logic [31:0] v;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 `CHK("oe_mid_reset", 16'hffff, {poe, moe})
      rd_reg(ADDR_CHCTRL_BASE + 8'h0c, v);
      `CHK("ctrl_reset", 32'h0000_0000, v)
   endtask : reset_mid
   task automatic close_out;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] v;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1 `CHK("oe_reset", 16'hffff, {poe, moe})
      wr_reg(8'h0c, 32'hffff_ffff);
      rd_reg(8'h0c, v);
      `CHK("unmapped", 32'h0000_0000, v)
      rd_reg(8'h21, v);
      `CHK("misaligned", 32'h0000_0000, v)
      wr_reg(ADDR_PERIOD, {21'h00_0000, PER});
      rd_reg(ADDR_PERIOD, v);
      `CHK("period", {21'h00_0000, PER}, v)
      for (int f = 0; f < 2; f++) begin
         for (int s = 0; s < 2; s++) begin
            set_fw(f[0]);
            cfg(0, ALIGN_LEFT, s[0] ? MODE_DUAL : MODE_FULL, s[0], 11'h001);
            watch(0, ALIGN_LEFT, MODE_FULL, s[0], 11'h001);
         end
      end
      cfg(0, ALIGN_LEFT, MODE_HALF_MINUS, 1'b1, 11'h002);
      watch(0, ALIGN_LEFT, MODE_HALF_MINUS, 1'b1, 11'h002);
      cfg(0, ALIGN_RIGHT, MODE_HALF_PLUS, 1'b1, 11'h002);
      watch(0, ALIGN_RIGHT, MODE_HALF_PLUS, 1'b1, 11'h002);
      set_fw(1'b0);
      watch(0, ALIGN_OFF, MODE_HALF_MINUS, 1'b0, 11'h000);
      cfg(1, ALIGN_CENTER, MODE_FULL, 1'b0, 11'h001);
      watch(1, ALIGN_CENTER, MODE_FULL, 1'b0, 11'h001);
      cfg(2, ALIGN_LEFT, MODE_DUAL, 1'b0, 11'h001);
      cfg(3, ALIGN_RIGHT, MODE_DUAL, 1'b1, 11'h001);
      cfg(4, ALIGN_LEFT, MODE_DUAL, 1'b0, 11'h001);
      rd_reg(ADDR_STATUS, v);
      `CHK("dual", 4'h2, v[3:0])
      `CHK("enabled", 8'h1e, v[15:8])
      watch(3, ALIGN_RIGHT, MODE_DUAL, 1'b1, 11'h001);
      regs_back();
      reset_mid();
      close_out();
   end
   initial begin
      #40000;
      n_fail++;
      close_out();
   end
endmodule : testbench
`default_nettype wire
